// [logic/wdt_reset_pkg.sv]
// Register map, field codes, reset values and timing constants for the watchdog and reset control
package wdt_reset_pkg;

	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_CONTROL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE_FLAGS = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_UNDERVOLT_KEY_REGISTER = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_UNDERVOLT_FILTER_REGISTER = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_PORT_DATA = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_PORT_DIR = 12'h018;

	// watchdog_control fields
	localparam int KEY_LSB = 3;
	localparam int KEY_MSB = 7;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 2;
	localparam logic [4:0] WDT_KEY_DISABLE = 5'h15;
	localparam logic [4:0] WDT_KEY_ENABLE = 5'h0a;
	localparam logic [7:0] WATCHDOG_CONTROL_POR = 8'h53;

	// undervolt key and filter
	localparam logic [7:0] UV_KEY_ENABLE = 8'h5a;
	localparam logic [7:0] UV_KEY_DISABLE = 8'ha5;
	localparam logic [7:0] UV_KEY_POR = 8'h5a;
	localparam logic [1:0] UV_FILTER_POR = 2'h1;

	// reset_cause_flags bit positions
	localparam int FLAG_WDT_KEY = 0;
	localparam int FLAG_UV_KEY = 1;
	localparam int FLAG_UV_RESET = 2;

	// status bit positions
	localparam int STAT_EXPIRY = 0;
	localparam int STAT_POWER_DOWN = 1;

	localparam int WDT_CNT_W = 15;
	localparam int WDT_BASE_EXP = 8;
	localparam int UV_CNT_W = 8;
	localparam logic [7:0] PORT_POR = 8'hff;

	// Delay from a key fault to the reset it causes
	localparam int CLK_PERIOD_NS = 10;
	localparam int KEY_FAULT_DELAY_NS = 100000;
	localparam int KEY_FAULT_DELAY_CYCLES = (KEY_FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [logic/watchdog_and_reset_control.sv]
// Watchdog timer, key-protected control fields and reset-cause logic behind an APB slave
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Disable key code stops the watchdog
// - Enable key code runs the watchdog
// - Bad watchdog key: delayed reset, fault flag
// - Watchdog key comes up holding enable
// - Timeout is 2^(8+select) slow periods
// - Watchdog key fault flag cleared by zero
// - Upper reset-cause bits read zero
// - Running overflow: full reset, expiry flag
// - Sleep overflow: both flags, PC/SP only
// - Key fault, clear or halt clears counter
// - Power-on clears the program counter
// - Power-on sets port registers all ones
// - Undervoltage must outlast filter time
// - Two-bit field selects filter time
// - Undervolt key enables or disables detection
// - Bad undervolt key: delayed reset, fault flag
// - Undervolt key comes up holding enable
// - Undervolt reset suspended in sleep/idle
// - Filter widths 8, 32, 64, 128 periods
// - Key fault restores key; real undervolt keeps it
// - Undervolt flags cleared only by zero write
module watchdog_and_reset_control
	import wdt_reset_pkg::*;
#(
	parameter int KEY_FAULT_DELAY = KEY_FAULT_DELAY_CYCLES,
	parameter int PORT_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_osc_tick,
	input wire logic watchdog_clear_instruction,
	input wire logic halt_instruction,
	input wire logic sleep_or_idle,
	input wire logic undervolt_detect,
	output logic device_reset,
	output logic pc_sp_clear,
	output logic watchdog_running,
	output logic watchdog_expiry_flag,
	output logic power_down_flag,
	output logic [PORT_W-1:0] port_data,
	output logic [PORT_W-1:0] port_dir
);

	// Registers, counters and fault tracking
	logic [7:0] watchdog_control;
	logic [7:0] undervolt_key_register;
	logic [1:0] undervolt_filter_select;
	logic [2:0] reset_cause_flags;
	logic [WDT_CNT_W-1:0] wdt_count;
	logic [UV_CNT_W-1:0] uv_count;
	logic uv_fired;
	logic [31:0] fault_delay;
	logic [1:0] fault_pending;

	// Decode, strobes and events
	logic access;
	logic wr_en;
	logic [4:0] wdt_key;
	logic wdt_enabled;
	logic wdt_key_bad;
	logic uv_key_bad;
	logic uv_active;
	logic wdt_overflow;
	logic uv_trip;
	logic fault_fire;
	logic full_reset;
	logic wr_watchdog_control;
	logic wr_reset_cause;
	logic wr_uv_key;
	logic wr_uv_filter;
	logic wr_port_data;
	logic wr_port_dir;
	logic [2:0] flag_set;

	function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [2:0] sel);
		wdt_limit = WDT_CNT_W'((32'h1 << (WDT_BASE_EXP + int'(sel))) - 32'h1);
	endfunction

	function automatic logic [UV_CNT_W-1:0] uv_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: uv_limit = 8'h08;
			2'h1: uv_limit = 8'h20;
			2'h2: uv_limit = 8'h40;
			2'h3: uv_limit = 8'h80;
		endcase
	endfunction

	// Register strobe decode, shared by every writable register
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
		reg_hit = (addr == target);
	endfunction

	function automatic logic wdt_key_valid(input logic [4:0] key);
		wdt_key_valid = (key == WDT_KEY_ENABLE) || (key == WDT_KEY_DISABLE);
	endfunction

	function automatic logic uv_key_valid(input logic [7:0] key);
		uv_key_valid = (key == UV_KEY_ENABLE) || (key == UV_KEY_DISABLE);
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
		unique case (addr)
			ADDR_WATCHDOG_CONTROL, ADDR_RESET_CAUSE_FLAGS, ADDR_UNDERVOLT_KEY_REGISTER, ADDR_UNDERVOLT_FILTER_REGISTER,
			ADDR_STATUS, ADDR_PORT_DATA, ADDR_PORT_DIR: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction

	assign access = psel & penable;
	assign wr_en = access & pready & pwrite & ~pslverr & clk_en;
	assign wdt_key = watchdog_control[KEY_MSB:KEY_LSB];
	assign wdt_enabled = (wdt_key == WDT_KEY_ENABLE);
	assign wdt_key_bad = !wdt_key_valid(wdt_key);
	assign uv_key_bad = !uv_key_valid(undervolt_key_register);
	assign uv_active = (undervolt_key_register == UV_KEY_ENABLE) && !sleep_or_idle;
	assign wdt_overflow = wdt_enabled && slow_osc_tick && (wdt_count == wdt_limit(watchdog_control[SEL_MSB:SEL_LSB]));
	assign uv_trip = uv_active && undervolt_detect && !uv_fired && slow_osc_tick
		&& (UV_CNT_W'(uv_count + 8'h01) == uv_limit(undervolt_filter_select));
	assign fault_fire = (fault_pending != 2'h0) && (fault_delay >= 32'(KEY_FAULT_DELAY - 1));
	assign full_reset = (wdt_overflow && !sleep_or_idle) || uv_trip || fault_fire;

	assign wr_watchdog_control = wr_en && reg_hit(paddr, ADDR_WATCHDOG_CONTROL);
	assign wr_reset_cause = wr_en && reg_hit(paddr, ADDR_RESET_CAUSE_FLAGS);
	assign wr_uv_key = wr_en && reg_hit(paddr, ADDR_UNDERVOLT_KEY_REGISTER);
	assign wr_uv_filter = wr_en && reg_hit(paddr, ADDR_UNDERVOLT_FILTER_REGISTER);
	assign wr_port_data = wr_en && reg_hit(paddr, ADDR_PORT_DATA);
	assign wr_port_dir = wr_en && reg_hit(paddr, ADDR_PORT_DIR);
	// Hardware set events for the reset-cause flags
	assign flag_set = {uv_trip, fault_fire & fault_pending[1], fault_fire & fault_pending[0]};

	// Bus handshake: one wait state, every answer registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else if (clk_en)
			pready <= access & ~pready;
	end

	// Unmapped offsets answer with an error and take no write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else if (clk_en)
			pslverr <= access & ~pready & ~addr_mapped(paddr);
	end

	// Read data captured once per access; bits above a register read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (clk_en)
		begin
			if (access & ~pready)
			begin
				prdata <= 32'h0;
				unique case (paddr)
					ADDR_WATCHDOG_CONTROL: prdata[7:0] <= watchdog_control;
					ADDR_RESET_CAUSE_FLAGS: prdata[2:0] <= reset_cause_flags;
					ADDR_UNDERVOLT_KEY_REGISTER: prdata[7:0] <= undervolt_key_register;
					ADDR_UNDERVOLT_FILTER_REGISTER: prdata[1:0] <= undervolt_filter_select;
					ADDR_STATUS: prdata[1:0] <= {power_down_flag, watchdog_expiry_flag};
					ADDR_PORT_DATA: prdata[PORT_W-1:0] <= port_data;
					ADDR_PORT_DIR: prdata[PORT_W-1:0] <= port_dir;
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// Watchdog control; a full reset restores the power-on value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			watchdog_control <= WATCHDOG_CONTROL_POR;
		else if (clk_en)
		begin
			if (full_reset)
				watchdog_control <= WATCHDOG_CONTROL_POR;
			else if (wr_watchdog_control)
				watchdog_control <= pwdata[7:0];
		end
	end

	// Undervolt key and filter; a genuine undervolt reset leaves them alone
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			undervolt_key_register <= UV_KEY_POR;
			undervolt_filter_select <= UV_FILTER_POR;
		end
		else if (clk_en)
		begin
			if (fault_fire && fault_pending[1])
				undervolt_key_register <= UV_KEY_POR;
			else if (wr_uv_key)
				undervolt_key_register <= pwdata[7:0];
			if (wr_uv_filter)
				undervolt_filter_select <= pwdata[1:0];
		end
	end

	// Watchdog counter on slow ticks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdt_count <= '0;
		else if (clk_en)
		begin
			if (wdt_key_bad || watchdog_clear_instruction || halt_instruction || wdt_overflow || full_reset)
				wdt_count <= '0;
			else if (wdt_enabled && slow_osc_tick)
				wdt_count <= WDT_CNT_W'(wdt_count + 15'h1);
		end
	end

	// Undervolt filter: short dips restart the count, one reset per dip
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			uv_count <= '0;
			uv_fired <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!uv_active || !undervolt_detect)
			begin
				uv_count <= '0;
				uv_fired <= 1'b0;
			end
			else if (uv_trip)
				uv_fired <= 1'b1;
			else if (slow_osc_tick && !uv_fired)
				uv_count <= UV_CNT_W'(uv_count + 8'h01);
		end
	end

	// Key faults share one delay counter; the noise may persist, so pending stays until the reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fault_pending <= 2'h0;
			fault_delay <= 32'h0;
		end
		else if (clk_en)
		begin
			if (full_reset)
			begin
				fault_pending <= 2'h0;
				fault_delay <= 32'h0;
			end
			else
			begin
				fault_pending <= fault_pending | {uv_key_bad, wdt_key_bad};
				if (fault_pending != 2'h0)
					fault_delay <= fault_delay + 32'h1;
			end
		end
	end

	// Reset cause flags: hardware set wins over a software zero write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_cause_flags <= 3'h0;
		else if (clk_en)
		begin
			if (wr_reset_cause)
				reset_cause_flags <= (reset_cause_flags & pwdata[2:0]) | flag_set;
			else
				reset_cause_flags <= reset_cause_flags | flag_set;
		end
	end

	// Status flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			watchdog_expiry_flag <= 1'b0;
			power_down_flag <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wdt_overflow)
			begin
				watchdog_expiry_flag <= 1'b1;
				if (sleep_or_idle)
					power_down_flag <= 1'b1;
			end
			else if (halt_instruction)
			begin
				power_down_flag <= 1'b1;
				watchdog_expiry_flag <= 1'b0;
			end
			else if (watchdog_clear_instruction)
			begin
				power_down_flag <= 1'b0;
				watchdog_expiry_flag <= 1'b0;
			end
		end
	end

	// Full reset request, one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			device_reset <= 1'b0;
		else if (clk_en)
			device_reset <= full_reset;
	end

	// Stands through power-on; a sleep overflow clears only program counter and stack
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pc_sp_clear <= 1'b1;
		else if (clk_en)
			pc_sp_clear <= full_reset || wdt_overflow;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			watchdog_running <= 1'b0;
		else if (clk_en)
			watchdog_running <= wdt_enabled;
	end

	// Port data: all ones means every pin is an input
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_data <= PORT_W'(PORT_POR);
		else if (clk_en)
		begin
			if (full_reset)
				port_data <= PORT_W'(PORT_POR);
			else if (wr_port_data)
				port_data <= pwdata[PORT_W-1:0];
		end
	end

	// Port direction, restored together with the data register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_dir <= PORT_W'(PORT_POR);
		else if (clk_en)
		begin
			if (full_reset)
				port_dir <= PORT_W'(PORT_POR);
			else if (wr_port_dir)
				port_dir <= pwdata[PORT_W-1:0];
		end
	end

endmodule
`default_nettype wire

// [testbench/wdt_chk_sva.sv]
// Port-level assertions for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
module wdt_chk
	import wdt_reset_pkg::*;
#(
	parameter int KEY_FAULT_DELAY = 5,
	parameter int PORT_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic sleep_or_idle,
	input wire logic watchdog_clear_instruction,
	input wire logic halt_instruction,
	input wire logic device_reset,
	input wire logic pc_sp_clear,
	input wire logic watchdog_running,
	input wire logic watchdog_expiry_flag,
	input wire logic power_down_flag,
	input wire logic [PORT_W-1:0] port_data,
	input wire logic [PORT_W-1:0] port_dir
);
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
logic wr_ok;
logic [4:0] wkey;
logic bad_key;
logic pend;
int wait_cnt;
assign wr_ok = psel && penable && pwrite && pready;
assign wkey = pwdata[KEY_MSB:KEY_LSB];
assign bad_key = wr_ok && ((paddr == ADDR_WATCHDOG_CONTROL && wkey != WDT_KEY_ENABLE && wkey != WDT_KEY_DISABLE)
	|| (paddr == ADDR_UNDERVOLT_KEY_REGISTER && pwdata[7:0] != UV_KEY_ENABLE && pwdata[7:0] != UV_KEY_DISABLE));
// Age of a key fault still waiting for its reset
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		pend <= 1'h0;
	else
		pend <= !device_reset && (pend || bad_key);
end
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		wait_cnt <= 0;
	else
		wait_cnt <= (pend && !device_reset) ? wait_cnt + 1 : 0;
end
AST_WDT_OFF: assert property (
	wr_ok && paddr == ADDR_WATCHDOG_CONTROL && wkey == WDT_KEY_DISABLE |-> ##[1:2] !watchdog_running)
	else $error("watchdog runs after disable key");
AST_WDT_ON: assert property (
	wr_ok && paddr == ADDR_WATCHDOG_CONTROL && wkey == WDT_KEY_ENABLE |-> ##[1:2] watchdog_running)
	else $error("watchdog idle after enable key");
AST_KEY_DELAY: assert property (
	pend |-> wait_cnt <= KEY_FAULT_DELAY + 3)
	else $error("key fault reset late");
AST_CAUSE_HI: assert property (
	psel && penable && pready && !pwrite && paddr == ADDR_RESET_CAUSE_FLAGS |-> prdata[31:3] == 29'h0)
	else $error("upper reset cause bits not zero");
AST_RUN_OVF: assert property (
	$rose(watchdog_expiry_flag) && !$past(sleep_or_idle) |-> device_reset && pc_sp_clear)
	else $error("running overflow without full reset");
AST_SLEEP_OVF: assert property (
	$rose(watchdog_expiry_flag) && $past(sleep_or_idle) |-> power_down_flag && pc_sp_clear && !device_reset)
	else $error("sleep overflow handled wrongly");
AST_CLEAR: assert property (
	watchdog_clear_instruction |=> !power_down_flag)
	else $error("clear left power down flag");
AST_HALT: assert property (
	halt_instruction |=> power_down_flag && !watchdog_expiry_flag)
	else $error("halt flags wrong");
AST_PORTS: assert property (
	$rose(presetn) |-> port_data == {PORT_W{1'b1}} && port_dir == {PORT_W{1'b1}})
	else $error("ports not all ones after reset");
endmodule
bind watchdog_and_reset_control wdt_chk #(.KEY_FAULT_DELAY(KEY_FAULT_DELAY), .PORT_W(PORT_W)) wdt_chk_i (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .sleep_or_idle,
	.watchdog_clear_instruction, .halt_instruction, .device_reset, .pc_sp_clear, .watchdog_running,
	.watchdog_expiry_flag, .power_down_flag, .port_data, .port_dir
);
`default_nettype wire

// [testbench/tb_watchdog_and_reset_control.sv]
// Self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_and_reset_control
	import wdt_reset_pkg::*;
;
logic pclk = 1'h0;
logic presetn = 1'h0;
logic [ADDR_W-1:0] paddr = 12'h0;
logic psel = 1'h0;
logic penable = 1'h0;
logic pwrite = 1'h0;
logic [31:0] pwdata = 32'h0;
logic slow_osc_tick = 1'h0;
logic watchdog_clear_instruction = 1'h0;
logic halt_instruction = 1'h0;
logic sleep_or_idle = 1'h0;
logic undervolt_detect = 1'h0;
logic clk_en = 1'h1;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic device_reset;
logic pc_sp_clear;
logic [7:0] port_data;
logic [7:0] port_dir;
logic [31:0] rd;
logic err;
int bad_count = 0;
int total_checks = 0;
int nrst = 0;
int npc = 0;
int r0;
int r1;
watchdog_and_reset_control #(.KEY_FAULT_DELAY(5)) watchdog_and_reset_control_i (
	.pclk, .presetn, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
	.pslverr, .slow_osc_tick, .watchdog_clear_instruction, .halt_instruction, .sleep_or_idle,
	.undervolt_detect, .device_reset, .pc_sp_clear, .watchdog_running(), .watchdog_expiry_flag(),
	.power_down_flag(), .port_data, .port_dir
);
always #5 pclk = ~pclk;
always @(posedge pclk)
begin
	if (presetn && device_reset === 1'h1)
		nrst <= nrst + 1;
	if (presetn && pc_sp_clear === 1'h1)
		npc <= npc + 1;
end
task automatic wrap_up;
	$display("checks %0d errors %0d", total_checks, bad_count);
	if (bad_count == 0 && total_checks > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	total_checks++;
	if (got !== exp)
	begin
		bad_count++;
		$display("[ERR] %0t got %h expected %h", $time, got, exp);
	end
endtask
task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
	@(posedge pclk);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	do
		@(posedge pclk);
	while (pready !== 1'h1);
	rd = prdata;
	err = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
endtask
task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
	apb(1'h0, a, 32'h0);
	chk(rd, exp);
endtask
// Trailing idle edges let a reset caused by the last tick be counted
task automatic tk(input int n);
	repeat (n)
	begin
		@(posedge pclk);
		slow_osc_tick <= 1'h1;
		@(posedge pclk);
		slow_osc_tick <= 1'h0;
	end
	repeat (3) @(posedge pclk);
endtask
task automatic pulse(input logic h);
	@(posedge pclk);
	halt_instruction <= h;
	watchdog_clear_instruction <= !h;
	@(posedge pclk);
	halt_instruction <= 1'h0;
	watchdog_clear_instruction <= 1'h0;
endtask
task automatic dip(input int n);
	@(posedge pclk);
	undervolt_detect <= 1'h1;
	tk(n);
	undervolt_detect <= 1'h0;
endtask
initial
begin
	#400000;
	bad_count++;
	wrap_up;
end
initial
begin
	repeat (5) @(posedge pclk);
	chk({31'h0, pc_sp_clear}, 32'h1);
	chk({16'h0, port_dir, port_data}, 32'hffff);
	presetn <= 1'h1;
	rdc(ADDR_WATCHDOG_CONTROL, 32'h53);
	rdc(ADDR_UNDERVOLT_KEY_REGISTER, 32'h5a);
	rdc(ADDR_UNDERVOLT_FILTER_REGISTER, 32'h1);
	rdc(ADDR_RESET_CAUSE_FLAGS, 32'h0);
	apb(1'h0, 12'h01c, 32'h0);
	chk({31'h0, err}, 32'h1);
	for (int s = 0; s < 2; s++)
	begin
		apb(1'h1, ADDR_WATCHDOG_CONTROL, {24'h0, WDT_KEY_ENABLE, s[2:0]});
		pulse(1'h0);
		r0 = nrst;
		tk((256 << s) - 1);
		chk(nrst, r0);
		tk(1);
		chk(nrst, r0 + 1);
		rdc(ADDR_STATUS, 32'h1);
	end
	pulse(1'h0);
	rdc(ADDR_STATUS, 32'h0);
	apb(1'h1, ADDR_WATCHDOG_CONTROL, 32'h50);
	r1 = nrst;
	tk(200);
	pulse(1'h0);
	tk(200);
	pulse(1'h1);
	tk(200);
	chk(nrst, r1);
	rdc(ADDR_STATUS, 32'h2);
	sleep_or_idle <= 1'h1;
	r0 = npc;
	tk(56);
	rdc(ADDR_STATUS, 32'h3);
	chk(npc, r0 + 1);
	chk(nrst, r1);
	sleep_or_idle <= 1'h0;
	apb(1'h1, ADDR_WATCHDOG_CONTROL, 32'ha8);
	tk(300);
	chk(nrst, r1);
	apb(1'h1, ADDR_WATCHDOG_CONTROL, 32'h0);
	repeat (12) @(posedge pclk);
	chk(nrst, r1 + 1);
	rdc(ADDR_RESET_CAUSE_FLAGS, 32'h1);
	rdc(ADDR_WATCHDOG_CONTROL, 32'h53);
	apb(1'h1, ADDR_RESET_CAUSE_FLAGS, 32'hff);
	rdc(ADDR_RESET_CAUSE_FLAGS, 32'h1);
	apb(1'h1, ADDR_RESET_CAUSE_FLAGS, 32'h0);
	rdc(ADDR_RESET_CAUSE_FLAGS, 32'h0);
	r0 = nrst;
	apb(1'h1, ADDR_UNDERVOLT_FILTER_REGISTER, 32'h0);
	dip(6);
	chk(nrst, r0);
	dip(9);
	chk(nrst, r0 + 1);
	rdc(ADDR_RESET_CAUSE_FLAGS, 32'h4);
	rdc(ADDR_UNDERVOLT_KEY_REGISTER, 32'h5a);
	apb(1'h1, ADDR_UNDERVOLT_KEY_REGISTER, 32'ha5);
	dip(40);
	chk(nrst, r0 + 1);
	apb(1'h1, ADDR_UNDERVOLT_KEY_REGISTER, 32'h5a);
	sleep_or_idle <= 1'h1;
	dip(40);
	sleep_or_idle <= 1'h0;
	chk(nrst, r0 + 1);
	clk_en <= 1'h0;
	dip(40);
	clk_en <= 1'h1;
	chk(nrst, r0 + 1);
	apb(1'h1, ADDR_UNDERVOLT_KEY_REGISTER, 32'h33);
	repeat (12) @(posedge pclk);
	chk(nrst, r0 + 2);
	rdc(ADDR_RESET_CAUSE_FLAGS, 32'h6);
	rdc(ADDR_UNDERVOLT_KEY_REGISTER, 32'h5a);
	wrap_up;
end
endmodule
`default_nettype wire
